/* rtl/gpb_port.sv */
// one general-purpose port: data, direction, interrupts, alternate function, commit guard, pad control
`timescale 1ns/1ps
module gpb_port
    import gpb_pkg::*;
#(
    parameter int P_PORT_INDEX = 0,
    parameter logic [7:0] P_BONDED = 8'hFF
) (
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    input wire logic [11:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WRITE,
    input wire logic I_READ,
    output logic [31:0] O_RDATA,
    input wire logic [7:0] I_PIN_IN,
    output logic [7:0] O_PIN_OUT,
    output logic [7:0] O_PIN_OE,
    input wire logic [7:0] I_ALT_OUT,
    input wire logic [7:0] I_ALT_OE,
    output logic [7:0] O_ALT_IN,
    output gpb_pad_s O_PAD,
    output logic O_IRQ,
    output logic O_CONVERTER_TRIGGER
);

    ////////////////////////////////////////////////////////////////////////////
    // reset values depend on which port this instance is
    localparam logic [7:0] DEBUG_PINS = gpb_debug_mask(P_PORT_INDEX);
    localparam logic [7:0] PROTECTED = DEBUG_PINS;
    localparam logic [7:0] COMMIT_RESET = ~DEBUG_PINS;
    localparam logic IS_PORT_B = (P_PORT_INDEX == GPB_PORT_B);

    gpb_state_s state_reg;
    gpb_state_s state_next;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [7:0] wmask;
        logic [7:0] rmask;
        logic [7:0] wbyte;
        logic [7:0] rise;
        logic [7:0] fall;
        logic [7:0] edge_hit;
        logic [7:0] level_hit;
        logic [7:0] clear_bits;
        logic [7:0] alt_writable;
        logic [7:0] masked_now;
        logic [7:0] drive_val;
        logic [7:0] drive_en;
        logic [3:0] id_index;
        logic in_data;
        logic in_id;
        logic [11:0] id_offset;
        wmask = '0;
        rmask = '0;
        wbyte = '0;
        rise = '0;
        fall = '0;
        edge_hit = '0;
        level_hit = '0;
        clear_bits = '0;
        alt_writable = '0;
        masked_now = '0;
        drive_val = '0;
        drive_en = '0;
        id_index = '0;
        id_offset = '0;
        in_data = 1'b0;
        in_id = 1'b0;
        state_next = state_reg;

        // pad inputs cross from the outside world; first stage feeds only the second
        state_next.sync_a = I_PIN_IN;
        state_next.sync_b = state_reg.sync_a;
        state_next.sync_prev = state_reg.sync_b;

        in_data = (I_ADDR[GPB_ADDR_W-1:GPB_REGION_LSB] == GPB_DATA_REGION);
        wmask = I_ADDR[GPB_MASK_MSB:GPB_MASK_LSB] & P_BONDED;
        rmask = I_ADDR[GPB_MASK_MSB:GPB_MASK_LSB] & P_BONDED;
        wbyte = I_WDATA[7:0] & P_BONDED;
        id_offset = I_ADDR - GPB_OFF_ID_BASE;
        in_id = (I_ADDR >= GPB_OFF_ID_BASE);
        id_index = id_offset[5:2];

        ////////////////////////////////////////////////////////////////////////
        // register writes; write data is masked to the bonded pins, so plain register writes store zero in unbonded bits
        if (I_WRITE) begin
            if (in_data) begin
                state_next.pin_value_reg = (state_reg.pin_value_reg & ~wmask) | (wbyte & wmask);
            end else begin
                unique case (I_ADDR)
                    GPB_OFF_DIR: begin
                        state_next.pin_direction_reg = wbyte;
                    end
                    GPB_OFF_SENSE: begin
                        state_next.irq_sense_select = wbyte;
                    end
                    GPB_OFF_BOTH: begin
                        state_next.irq_both_edge_select = wbyte;
                    end
                    GPB_OFF_EVENT: begin
                        state_next.irq_event_polarity = wbyte;
                    end
                    GPB_OFF_MASK: begin
                        state_next.irq_mask = wbyte;
                    end
                    GPB_OFF_CLEAR: begin
                        clear_bits = wbyte;
                    end
                    GPB_OFF_ALT: begin
                        // debug pins keep their function unless deliberately released
                        alt_writable = ~PROTECTED | (state_reg.commit_permit & {8{state_reg.unlocked}});
                        state_next.alt_function_select =
                            (state_reg.alt_function_select & ~alt_writable) | (wbyte & alt_writable);
                    end
                    GPB_OFF_DRV2: begin
                        // one drive strength per pin: selecting one clears the others
                        state_next.pad.drive_low = state_reg.pad.drive_low | wbyte;
                        state_next.pad.drive_mid = state_reg.pad.drive_mid & ~wbyte;
                        state_next.pad.drive_high = state_reg.pad.drive_high & ~wbyte;
                    end
                    GPB_OFF_DRV4: begin
                        state_next.pad.drive_mid = state_reg.pad.drive_mid | wbyte;
                        state_next.pad.drive_low = state_reg.pad.drive_low & ~wbyte;
                        state_next.pad.drive_high = state_reg.pad.drive_high & ~wbyte;
                    end
                    GPB_OFF_DRV8: begin
                        state_next.pad.drive_high = state_reg.pad.drive_high | wbyte;
                        state_next.pad.drive_low = state_reg.pad.drive_low & ~wbyte;
                        state_next.pad.drive_mid = state_reg.pad.drive_mid & ~wbyte;
                    end
                    GPB_OFF_ODRAIN: begin
                        state_next.pad.open_drain = wbyte;
                    end
                    GPB_OFF_PULLUP: begin
                        state_next.pad.pull_up = wbyte;
                    end
                    GPB_OFF_PULLDN: begin
                        state_next.pad.pull_down = wbyte;
                    end
                    GPB_OFF_SLEW: begin
                        state_next.slew_select = wbyte;
                    end
                    GPB_OFF_DEN: begin
                        state_next.pad.digital_en = wbyte;
                    end
                    GPB_OFF_LOCK: begin
                        // any value but the key relocks
                        state_next.unlocked = (I_WDATA == GPB_LOCK_KEY);
                    end
                    GPB_OFF_COMMIT: begin
                        if (state_reg.unlocked) begin
                            state_next.commit_permit = (state_reg.commit_permit & ~PROTECTED) | (wbyte & PROTECTED);
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // input pins: the data bit follows the synchronised level while the digital enable is set, else it is zero
        state_next.pin_value_reg = (state_next.pin_value_reg & state_reg.pin_direction_reg)
            | (state_reg.sync_b & state_reg.pad.digital_en & ~state_reg.pin_direction_reg & P_BONDED);

        ////////////////////////////////////////////////////////////////////////
        // interrupt detection on the synchronised pins
        rise = state_reg.sync_b & ~state_reg.sync_prev;
        fall = ~state_reg.sync_b & state_reg.sync_prev;
        edge_hit = (state_reg.irq_both_edge_select & (rise | fall))
            | (~state_reg.irq_both_edge_select & state_reg.irq_event_polarity & rise)
            | (~state_reg.irq_both_edge_select & ~state_reg.irq_event_polarity & fall);
        level_hit = ~(state_reg.sync_b ^ state_reg.irq_event_polarity);
        // a clear never cancels an edge seen in the same cycle
        state_next.irq_raw_status = P_BONDED & (
            (state_reg.irq_sense_select & level_hit)
            | (~state_reg.irq_sense_select & ((state_reg.irq_raw_status & ~clear_bits) | edge_hit)));
        masked_now = state_next.irq_raw_status & state_next.irq_mask;
        state_next.irq = |masked_now;
        state_next.trigger = IS_PORT_B & masked_now[GPB_TRIGGER_BIT]
            & ~(state_reg.irq_raw_status[GPB_TRIGGER_BIT] & state_reg.irq_mask[GPB_TRIGGER_BIT]);

        ////////////////////////////////////////////////////////////////////////
        // pad drive: peripheral or data register, open drain only pulls low
        drive_val = (state_next.alt_function_select & I_ALT_OUT)
            | (~state_next.alt_function_select & state_next.pin_value_reg);
        drive_en = (state_next.alt_function_select & I_ALT_OE)
            | (~state_next.alt_function_select & state_next.pin_direction_reg);
        state_next.pin_out = drive_val & ~state_next.pad.open_drain & P_BONDED;
        state_next.pin_oe = drive_en & state_next.pad.digital_en & P_BONDED
            & (~state_next.pad.open_drain | ~drive_val);
        state_next.alt_in = state_reg.sync_b & state_reg.pad.digital_en & state_reg.alt_function_select;
        // slew control only means something at the strongest drive
        state_next.pad.slew = state_next.slew_select & state_next.pad.drive_high;

        ////////////////////////////////////////////////////////////////////////
        // read data stands only in the cycle after the strobe
        state_next.rdata = '0;
        if (I_READ) begin
            if (in_data) begin
                state_next.rdata = {24'h000000, state_reg.pin_value_reg & rmask};
            end else if (in_id) begin
                if (id_index < 4'(GPB_ID_WORDS)) begin
                    state_next.rdata = {24'h000000, GPB_ID_BYTES[id_index]};
                end
            end else begin
                unique case (I_ADDR)
                    GPB_OFF_DIR: state_next.rdata = {24'h000000, state_reg.pin_direction_reg & P_BONDED};
                    GPB_OFF_SENSE: state_next.rdata = {24'h000000, state_reg.irq_sense_select};
                    GPB_OFF_BOTH: state_next.rdata = {24'h000000, state_reg.irq_both_edge_select};
                    GPB_OFF_EVENT: state_next.rdata = {24'h000000, state_reg.irq_event_polarity};
                    GPB_OFF_MASK: state_next.rdata = {24'h000000, state_reg.irq_mask};
                    GPB_OFF_RAW: state_next.rdata = {24'h000000, state_reg.irq_raw_status};
                    GPB_OFF_MASKED: state_next.rdata = {24'h000000,
                        state_reg.irq_raw_status & state_reg.irq_mask};
                    GPB_OFF_ALT: state_next.rdata = {24'h000000, state_reg.alt_function_select};
                    GPB_OFF_DRV2: state_next.rdata = {24'h000000, state_reg.pad.drive_low};
                    GPB_OFF_DRV4: state_next.rdata = {24'h000000, state_reg.pad.drive_mid};
                    GPB_OFF_DRV8: state_next.rdata = {24'h000000, state_reg.pad.drive_high};
                    GPB_OFF_ODRAIN: state_next.rdata = {24'h000000, state_reg.pad.open_drain};
                    GPB_OFF_PULLUP: state_next.rdata = {24'h000000, state_reg.pad.pull_up};
                    GPB_OFF_PULLDN: state_next.rdata = {24'h000000, state_reg.pad.pull_down};
                    GPB_OFF_SLEW: state_next.rdata = {24'h000000, state_reg.slew_select};
                    GPB_OFF_DEN: state_next.rdata = {24'h000000, state_reg.pad.digital_en};
                    GPB_OFF_LOCK: state_next.rdata = state_reg.unlocked ? GPB_LOCK_OPEN : GPB_LOCK_LOCKED;
                    GPB_OFF_COMMIT: state_next.rdata = {24'h000000, state_reg.commit_permit};
                    default: state_next.rdata = '0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // one asynchronous reset covers power-on and the reset pin alike
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state_reg <= '0;
            state_reg.alt_function_select <= DEBUG_PINS;
            state_reg.pad.digital_en <= DEBUG_PINS;
            state_reg.pad.pull_up <= DEBUG_PINS;
            state_reg.pad.drive_low <= GPB_RST_DRV2;
            state_reg.commit_permit <= COMMIT_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign O_RDATA = state_reg.rdata;
    assign O_PIN_OUT = state_reg.pin_out;
    assign O_PIN_OE = state_reg.pin_oe;
    assign O_ALT_IN = state_reg.alt_in;
    assign O_PAD = state_reg.pad;
    assign O_IRQ = state_reg.irq;
    assign O_CONVERTER_TRIGGER = state_reg.trigger;

endmodule : gpb_port

/* rtl/gpb_pkg.sv */
// package: constants, register map and state types for the general-purpose port block
package gpb_pkg;

    localparam int GPB_PINS = 8;
    localparam int GPB_ADDR_W = 12;
    localparam int GPB_DATA_W = 32;

    // register byte offsets inside one port
    localparam logic [11:0] GPB_OFF_DIR = 12'h400;
    localparam logic [11:0] GPB_OFF_SENSE = 12'h404;
    localparam logic [11:0] GPB_OFF_BOTH = 12'h408;
    localparam logic [11:0] GPB_OFF_EVENT = 12'h40C;
    localparam logic [11:0] GPB_OFF_MASK = 12'h410;
    localparam logic [11:0] GPB_OFF_RAW = 12'h414;
    localparam logic [11:0] GPB_OFF_MASKED = 12'h418;
    localparam logic [11:0] GPB_OFF_CLEAR = 12'h41C;
    localparam logic [11:0] GPB_OFF_ALT = 12'h420;
    localparam logic [11:0] GPB_OFF_DRV2 = 12'h500;
    localparam logic [11:0] GPB_OFF_DRV4 = 12'h504;
    localparam logic [11:0] GPB_OFF_DRV8 = 12'h508;
    localparam logic [11:0] GPB_OFF_ODRAIN = 12'h50C;
    localparam logic [11:0] GPB_OFF_PULLUP = 12'h510;
    localparam logic [11:0] GPB_OFF_PULLDN = 12'h514;
    localparam logic [11:0] GPB_OFF_SLEW = 12'h518;
    localparam logic [11:0] GPB_OFF_DEN = 12'h51C;
    localparam logic [11:0] GPB_OFF_LOCK = 12'h520;
    localparam logic [11:0] GPB_OFF_COMMIT = 12'h524;
    localparam logic [11:0] GPB_OFF_ID_BASE = 12'hFD0;

    // data window: address bits [11:10] zero, bits [9:2] are the pin mask
    localparam logic [1:0] GPB_DATA_REGION = 2'h0;
    localparam int GPB_MASK_LSB = 2;
    localparam int GPB_MASK_MSB = 9;
    localparam int GPB_REGION_LSB = 10;

    localparam logic [31:0] GPB_LOCK_KEY = 32'h1ACCE551;
    localparam logic [31:0] GPB_LOCK_LOCKED = 32'h00000001;
    localparam logic [31:0] GPB_LOCK_OPEN = 32'h00000000;

    localparam logic [7:0] GPB_RST_ZERO = 8'h00;
    localparam logic [7:0] GPB_RST_DRV2 = 8'hFF;
    localparam logic [7:0] GPB_DEBUG_B = 8'h80;
    localparam logic [7:0] GPB_DEBUG_C = 8'h0F;
    localparam int GPB_PORT_B = 1;
    localparam int GPB_PORT_C = 2;
    localparam int GPB_TRIGGER_BIT = 4;

    // identification bytes: eight peripheral words then four cell words (values arbitrary)
    localparam int GPB_ID_WORDS = 12;
    localparam logic [7:0] GPB_ID_BYTES [GPB_ID_WORDS] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h5A, 8'h11, 8'h22, 8'h01,
        8'h3C, 8'hA0, 8'h0B, 8'hC5
    };

    typedef struct packed {
        logic [7:0] pull_up;
        logic [7:0] pull_down;
        logic [7:0] open_drain;
        logic [7:0] drive_low;
        logic [7:0] drive_mid;
        logic [7:0] drive_high;
        logic [7:0] slew;
        logic [7:0] digital_en;
    } gpb_pad_s;

    typedef struct packed {
        logic [7:0] pin_value_reg;
        logic [7:0] pin_direction_reg;
        logic [7:0] irq_sense_select;
        logic [7:0] irq_both_edge_select;
        logic [7:0] irq_event_polarity;
        logic [7:0] irq_mask;
        logic [7:0] irq_raw_status;
        logic [7:0] alt_function_select;
        logic [7:0] slew_select;
        logic [7:0] commit_permit;
        logic unlocked;
        logic [7:0] sync_a;
        logic [7:0] sync_b;
        logic [7:0] sync_prev;
        gpb_pad_s pad;
        logic [7:0] pin_out;
        logic [7:0] pin_oe;
        logic [7:0] alt_in;
        logic irq;
        logic trigger;
        logic [31:0] rdata;
    } gpb_state_s;

    function automatic logic [7:0] gpb_debug_mask(input int port);
        if (port == GPB_PORT_B) begin
            return GPB_DEBUG_B;
        end
        if (port == GPB_PORT_C) begin
            return GPB_DEBUG_C;
        end
        return GPB_RST_ZERO;
    endfunction : gpb_debug_mask

endpackage : gpb_pkg

/* test/gpb_port_properties.sv */
// checker: port-level properties of one general-purpose port
`timescale 1ns/1ps
module gpb_port_chk
    import gpb_pkg::*;
(
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    input wire logic [11:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WRITE,
    input wire logic I_READ,
    input wire logic [31:0] O_RDATA,
    input wire logic [7:0] O_ALT_IN,
    input wire gpb_pad_s O_PAD,
    input wire logic O_IRQ,
    input wire logic O_CONVERTER_TRIGGER
);
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_N);
    sequence s_wr(logic [11:0] a);
        I_WRITE && I_ADDR == a;
    endsequence
    property p_rd_idle;
        !$past(I_READ) |-> O_RDATA == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
    property p_rd_mask;
        I_READ && I_ADDR[11:10] == GPB_DATA_REGION |=> (O_RDATA[7:0] & ~$past(I_ADDR[9:2])) == 8'h00;
    endproperty
    a_rd_mask: assert property (p_rd_mask) else $error("masked data bit read nonzero");
    property p_id;
        I_READ && I_ADDR >= GPB_OFF_ID_BASE && I_ADDR[1:0] == 2'h0
            |=> O_RDATA == {24'h0, GPB_ID_BYTES[$past(I_ADDR[5:2]) - 4'h4]};
    endproperty
    a_id: assert property (p_id) else $error("identification word wrong");
    property p_trig_pulse;
        O_CONVERTER_TRIGGER |=> !O_CONVERTER_TRIGGER;
    endproperty
    a_trig_pulse: assert property (p_trig_pulse) else $error("trigger longer than one cycle");
    property p_trig_irq;
        O_CONVERTER_TRIGGER |-> O_IRQ;
    endproperty
    a_trig_irq: assert property (p_trig_irq) else $error("trigger without port interrupt");
    property p_mask_off;
        s_wr(GPB_OFF_MASK) ##0 (I_WDATA[7:0] == 8'h00) |=> ##1 !O_IRQ;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("interrupt with all pins masked");
    property p_drv8;
        s_wr(GPB_OFF_DRV8) |=> O_PAD.drive_high == ($past(O_PAD.drive_high) | $past(I_WDATA[7:0]))
            && (O_PAD.drive_low & $past(I_WDATA[7:0])) == 8'h00;
    endproperty
    a_drv8: assert property (p_drv8) else $error("drive select write wrong");
    // peripheral input lags the enable by a cycle, so both samples must be clear
    property p_alt_in;
        (O_ALT_IN & ~O_PAD.digital_en & ~$past(O_PAD.digital_en)) == 8'h00;
    endproperty
    a_alt_in: assert property (p_alt_in) else $error("peripheral input without enable");
endmodule : gpb_port_chk
////////////////////////////////////////////////////////////
bind gpb_port gpb_port_chk u_chk (
    .I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WRITE(I_WRITE),
    .I_READ(I_READ), .O_RDATA(O_RDATA), .O_ALT_IN(O_ALT_IN), .O_PAD(O_PAD), .O_IRQ(O_IRQ),
    .O_CONVERTER_TRIGGER(O_CONVERTER_TRIGGER)
);

/* test/gpb_pin_model.sv */
// partner model: pads and peripheral alternate functions beside one port
`timescale 1ns/1ps
module gpb_pin_model (
    input wire logic i_clock,
    input wire logic [7:0] i_ext_level,
    input wire logic [7:0] i_alt_out_req,
    input wire logic [7:0] i_alt_oe_req,
    input wire logic [7:0] i_pin_out,
    input wire logic [7:0] i_pin_oe,
    output logic [7:0] o_pin_in,
    output logic [7:0] o_alt_out,
    output logic [7:0] o_alt_oe
);
    // outside source holds its level until the bench moves it
    assign o_pin_in = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_level);
    // peripheral side is one register stage behind its request, like on-chip logic
    always @(posedge i_clock) begin
        o_alt_out <= i_alt_out_req;
        o_alt_oe <= i_alt_oe_req;
    end
endmodule : gpb_pin_model

/* test/testbench.sv */
// testbench: one port B instance against its pad and peripheral model
`timescale 1ns/1ps
module testbench
    import gpb_pkg::*;
;
    localparam logic [4:0] SEN = 5'h18;
    localparam logic [4:0] BTH = 5'h04;
    localparam logic [4:0] EVT = 5'h0D;
    logic clock, rst_n, wr_en, rd_en, irq, trig;
    logic [11:0] addr;
    logic [31:0] wdata, rdata;
    logic [7:0] pin_in, pin_out, pin_oe, alt_out, alt_oe, alt_in, ext_lvl, alt_oreq, alt_ereq, m, w, mdl;
    gpb_pad_s pad;
    int err_total, checks, cycles, trig_cnt;
    logic [11:0] rst_a [9] = '{GPB_OFF_ALT, GPB_OFF_PULLUP, GPB_OFF_DEN, GPB_OFF_DRV2, GPB_OFF_DRV4,
        GPB_OFF_PULLDN, GPB_OFF_COMMIT, GPB_OFF_DIR, GPB_OFF_LOCK};
    logic [7:0] rst_v [9] = '{8'h80, 8'h80, 8'h80, 8'hFF, 8'h00, 8'h00, 8'h7F, 8'h00, 8'h01};
    logic [11:0] reg_a [6] = '{GPB_OFF_DIR, GPB_OFF_SENSE, GPB_OFF_BOTH, GPB_OFF_EVENT, GPB_OFF_PULLDN,
        GPB_OFF_ODRAIN};
    gpb_port #(.P_PORT_INDEX(GPB_PORT_B)) dut (
        .I_CLOCK(clock), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WRITE(wr_en), .I_READ(rd_en),
        .O_RDATA(rdata), .I_PIN_IN(pin_in), .O_PIN_OUT(pin_out), .O_PIN_OE(pin_oe), .I_ALT_OUT(alt_out),
        .I_ALT_OE(alt_oe), .O_ALT_IN(alt_in), .O_PAD(pad), .O_IRQ(irq), .O_CONVERTER_TRIGGER(trig)
    );
    gpb_pin_model pads (
        .i_clock(clock), .i_ext_level(ext_lvl), .i_alt_out_req(alt_oreq), .i_alt_oe_req(alt_ereq),
        .i_pin_out(pin_out), .i_pin_oe(pin_oe), .o_pin_in(pin_in), .o_alt_out(alt_out), .o_alt_oe(alt_oe)
    );
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // strobe drops with a gap edge, so back-to-back calls never reassign it in one step
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr_en <= 1'b0;
        @(posedge clock);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 chk(rdata, e);
        @(posedge clock);
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc
    task automatic chk_rst;
        for (int i = 0; i < 9; i++) begin
            rd(rst_a[i], {24'h0, rst_v[i]});
        end
    endtask : chk_rst
    task end_sim;
        if (err_total == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (trig === 1'b1) begin
            trig_cnt++;
        end
        if (cycles == 20000) begin
            err_total++;
            end_sim();
        end
    end
    initial begin
        rst_n = 1'b0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 12'h000;
        wdata = 32'h0;
        ext_lvl = 8'h00;
        alt_oreq = 8'h00;
        alt_ereq = 8'h00;
        void'($urandom(13));
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        chk_rst();
        for (int i = 0; i < 6; i++) begin
            w = 8'($urandom);
            wr(reg_a[i], {24'h0, w});
            rd(reg_a[i], {24'h0, w});
            wr(reg_a[i], 32'h0);
        end
        wr(GPB_OFF_ID_BASE, 32'hFF);
        for (int i = 0; i < 12; i++) begin
            rd(GPB_OFF_ID_BASE + 12'(i * 4), {24'h0, GPB_ID_BYTES[i]});
        end
        // pin 0 is unprotected so it lands while locked; pin 7 must not
        wr(GPB_OFF_ALT, 32'h01);
        rd(GPB_OFF_ALT, 32'h81);
        wr(GPB_OFF_LOCK, GPB_LOCK_KEY);
        rd(GPB_OFF_LOCK, GPB_LOCK_OPEN);
        wr(GPB_OFF_COMMIT, 32'hFF);
        wr(GPB_OFF_ALT, 32'h00);
        rd(GPB_OFF_ALT, 32'h00);
        wr(GPB_OFF_LOCK, 32'h0);
        rd(GPB_OFF_LOCK, GPB_LOCK_LOCKED);
        wr(GPB_OFF_ALT, 32'h80);
        rd(GPB_OFF_ALT, 32'h00);
        // output enable needs the digital enable as well
        wr(GPB_OFF_DEN, 32'hFF);
        wr(GPB_OFF_DIR, 32'hFF);
        wr(12'h3FC, 32'h0);
        mdl = 8'h00;
        for (int i = 0; i < 8; i++) begin
            m = (i == 0) ? 8'h26 : 8'($urandom);
            w = (i == 0) ? 8'hEB : 8'($urandom);
            wr({2'h0, m, 2'h0}, {24'h0, w});
            mdl = (mdl & ~m) | (w & m);
            chk({16'h0, pin_oe, pin_out}, {16'h0, 8'hFF, mdl});
            m = 8'($urandom);
            rd({2'h0, m, 2'h0}, {24'h0, mdl & m});
        end
        wr(GPB_OFF_DIR, 32'h0);
        wr(GPB_OFF_DEN, 32'hFF);
        for (int i = 0; i < 4; i++) begin
            ext_lvl <= 8'($urandom);
            cyc(4);
            rd(12'h3FC, {24'h0, ext_lvl});
        end
        wr(GPB_OFF_ALT, 32'h01);
        alt_oreq <= 8'h01;
        alt_ereq <= 8'h01;
        // model stage, drive, two sync flops, then the peripheral input register
        cyc(6);
        chk({29'h0, pin_oe[0], pin_out[0], alt_in[0]}, 32'h7);
        alt_ereq <= 8'h00;
        ext_lvl <= 8'h00;
        cyc(6);
        chk({30'h0, pin_oe[0], alt_in[0]}, 32'h0);
        wr(GPB_OFF_ALT, 32'h0);
        ////////////////////////////////////////////////////////////
        for (int k = 0; k < 5; k++) begin
            wr(GPB_OFF_MASK, 32'h0);
            ext_lvl <= EVT[k] ? 8'h00 : 8'h10;
            cyc(4);
            wr(GPB_OFF_SENSE, {27'h0, SEN[k], 4'h0});
            wr(GPB_OFF_BOTH, {27'h0, BTH[k], 4'h0});
            wr(GPB_OFF_EVENT, {27'h0, EVT[k], 4'h0});
            wr(GPB_OFF_CLEAR, 32'hFF);
            ext_lvl <= EVT[k] ? 8'h10 : 8'h00;
            cyc(4);
            rd(GPB_OFF_RAW, 32'h10);
            rd(GPB_OFF_MASKED, 32'h0);
            chk({31'h0, irq}, 32'h0);
            wr(GPB_OFF_MASK, 32'h10);
            cyc(2);
            chk({31'h0, irq}, 32'h1);
            rd(GPB_OFF_MASKED, 32'h10);
            wr(GPB_OFF_CLEAR, 32'h0);
            rd(GPB_OFF_RAW, 32'h10);
            ext_lvl <= EVT[k] ? 8'h00 : 8'h10;
            cyc(4);
            rd(GPB_OFF_RAW, SEN[k] ? 32'h0 : 32'h10);
            wr(GPB_OFF_CLEAR, 32'h10);
            cyc(2);
            rd(GPB_OFF_RAW, 32'h0);
            chk({31'h0, irq}, 32'h0);
        end
        chk(32'(trig_cnt), 32'h5);
        wr(GPB_OFF_DRV8, 32'h0F);
        chk({16'h0, pad.drive_high, pad.drive_low}, 32'h0FF0);
        wr(GPB_OFF_SLEW, 32'hFF);
        chk({24'h0, pad.slew}, 32'h0F);
        rst_n <= 1'b0;
        cyc(3);
        rst_n <= 1'b1;
        chk({24'h0, pad.pull_up}, 32'h80);
        chk_rst();
        end_sim();
    end
endmodule : testbench
